// [design/blsu_agen.sv]
// effective address and pointer write-back calculator
// assumes the circular wrap of index forms is applied outside
`timescale 1ns/1ps

module blsu_agen
    import blsu_pkg::*;
(
    // operation
    input  wire blsu_pkg::blsu_op_e op,
    input  wire blsu_pkg::blsu_am_e mode,
    input  wire logic [31:0]        base,
    input  wire logic [31:0]        step_reg,
    input  wire logic [16:0]        imm,
    input  wire logic               same_ptr,
    // results
    output logic [31:0]             addr,
    output logic [31:0]             new_base,
    output logic                    base_we,
    output logic                    misaligned
);
    logic [31:0] step;

    always_comb
    begin
        step     = (op == BLSU_OP_LDSB) ? BLSU_BYTE_STEP : BLSU_WORD_STEP;
        addr     = base;
        new_base = base;
        base_we  = 1'b0;
        case (mode)
            BLSU_AM_PLAIN, BLSU_AM_I_PLAIN: ;
            BLSU_AM_POSTINC, BLSU_AM_I_POSTINC:
            begin
                new_base = base + step;
                base_we  = 1'b1;
            end
            BLSU_AM_POSTDEC, BLSU_AM_I_POSTDEC:
            begin
                new_base = base - step;
                base_we  = 1'b1;
            end
            BLSU_AM_SMALL_OFF:
                addr = base + {26'h0, imm[5:2], 2'h0};
            BLSU_AM_LARGE_ADD:
                // byte load uses 15 bits, word stores 17 bits word-aligned
                addr = (op == BLSU_OP_LDSB) ? base + {17'h0, imm[14:0]}
                                            : base + {15'h0, imm[16:2], 2'h0};
            BLSU_AM_LARGE_SUB:
                addr = (op == BLSU_OP_LDSB) ? base - {17'h0, imm[14:0]}
                                            : base - {15'h0, imm[16:2], 2'h0};
            BLSU_AM_FRAME:
                addr = base - {24'h0, imm[7:2], 2'h0};
            BLSU_AM_PTR_IDX:
            begin
                new_base = base + step_reg;
                base_we  = !same_ptr;
            end
            BLSU_AM_I_MOD:
            begin
                new_base = base + step_reg;
                base_we  = 1'b1;
            end
            default: ;
        endcase
        // byte loads never check alignment
        misaligned = (op != BLSU_OP_LDSB) && ((addr[1:0] & BLSU_ALIGN_MASK) != 2'h0);
    end

endmodule // blsu_agen

// [design/blsu_pkg.sv]
// package for the byte load / word store unit
// assumes a 32-bit core with 8 pointer, 8 data, 4 index and 4 modify registers
package blsu_pkg;

    // ****************************************************************
    // operations and addressing modes
    // ****************************************************************
    typedef enum logic [1:0] {BLSU_OP_LDSB, BLSU_OP_STP, BLSU_OP_STD} blsu_op_e;

    typedef enum logic [3:0]
    {
        BLSU_AM_PLAIN,
        BLSU_AM_POSTINC,
        BLSU_AM_POSTDEC,
        BLSU_AM_SMALL_OFF,
        BLSU_AM_LARGE_ADD,
        BLSU_AM_LARGE_SUB,
        BLSU_AM_FRAME,
        BLSU_AM_PTR_IDX,
        BLSU_AM_I_PLAIN,
        BLSU_AM_I_POSTINC,
        BLSU_AM_I_POSTDEC,
        BLSU_AM_I_MOD
    } blsu_am_e;

    // ****************************************************************
    // sizes, steps and immediate widths
    // ****************************************************************
    localparam int          BLSU_DATA_W      = 32;
    localparam int          BLSU_BYTE_W      = 8;
    localparam int          BLSU_BYTE_IMM_W  = 15;
    localparam int          BLSU_SMALL_IMM_W = 6;
    localparam int          BLSU_LARGE_IMM_W = 17;
    localparam int          BLSU_FRAME_IMM_W = 8;
    localparam logic [31:0] BLSU_BYTE_STEP   = 32'h0000_0001;
    localparam logic [31:0] BLSU_WORD_STEP   = 32'h0000_0004;
    localparam logic [1:0]  BLSU_ALIGN_MASK  = 2'h3;
    localparam logic [2:0]  BLSU_FRAME_POINTER_INDEX = 3'h7;
    localparam logic [2:0]  BLSU_STACK_POINTER_INDEX = 3'h6;

endpackage

// [design/blsu_unit.sv]
// byte load / word store execution unit with its own register files
// assumes a single-cycle data memory: load data valid in the same cycle that mem_req is high
`timescale 1ns/1ps

module blsu_unit
    import blsu_pkg::*;
(
    // clock and reset
    input  wire logic               clock,
    input  wire logic               rstn,
    // instruction issue
    input  wire logic               issue_valid,
    input  wire blsu_pkg::blsu_op_e issue_op,
    input  wire blsu_pkg::blsu_am_e issue_mode,
    input  wire logic [2:0]         ptr_sel,
    input  wire logic [2:0]         ptr2_sel,
    input  wire logic [1:0]         idx_sel,
    input  wire logic [1:0]         mod_sel,
    input  wire logic [2:0]         src_sel,
    input  wire logic [2:0]         dst_sel,
    input  wire logic [16:0]        imm,
    input  wire logic               issue_parallel,
    // register preload from the rest of the core
    input  wire logic               dreg_wr,
    input  wire logic [2:0]         dreg_wr_sel,
    input  wire logic [31:0]        dreg_wr_data,
    input  wire logic               preg_wr,
    input  wire logic [2:0]         preg_wr_sel,
    input  wire logic [31:0]        preg_wr_data,
    input  wire logic               dag_wr,
    input  wire logic [1:0]         dag_wr_sel,
    input  wire logic [31:0]        dag_wr_index,
    input  wire logic [31:0]        dag_wr_length,
    input  wire logic [31:0]        dag_wr_base,
    input  wire logic [31:0]        dag_wr_modify,
    // data memory port
    output logic                    mem_req,
    output logic                    mem_we,
    output logic [31:0]             mem_addr,
    output logic [31:0]             mem_wdata,
    input  wire logic [31:0]        mem_rdata,
    // status
    output logic                    long_insn,
    output logic                    issue_refused,
    output logic                    misalign_exc,
    output logic                    done,
    output logic [31:0]             dreg_view [8],
    output logic [31:0]             preg_view [8]
);
    logic [31:0] dreg [8];
    logic [31:0] preg [8];
    logic [31:0] ireg [4];
    logic [31:0] lreg [4];
    logic [31:0] breg [4];
    logic [31:0] mreg [4];

    logic        is_long;
    logic        is_index;
    logic        accept;
    logic [31:0] base;
    logic [31:0] step_reg;
    logic [31:0] ea;
    logic [31:0] new_base;
    logic [31:0] next_index;
    logic        base_we;
    logic        misaligned;
    logic        load_pending;
    logic [2:0]  load_dst;

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    // the slices below are fixed, so other package sizes are refused
    if (BLSU_DATA_W != 32)
    begin : g_check_data_w
        $error("blsu_unit needs a 32-bit data path");
    end

    if (BLSU_BYTE_W != 8)
    begin : g_check_byte_w
        $error("blsu_unit sign-extends from bit 7 only");
    end

    if (BLSU_BYTE_IMM_W != 15)
    begin : g_check_byte_imm_w
        $error("blsu_unit byte offset is taken from imm bits 14 to 0");
    end

    if (BLSU_SMALL_IMM_W != 6)
    begin : g_check_small_imm_w
        $error("blsu_unit small word offset is taken from imm bits 5 to 2");
    end

    if (BLSU_LARGE_IMM_W != 17)
    begin : g_check_large_imm_w
        $error("blsu_unit large word offset must match the 17-bit imm port");
    end

    if (BLSU_FRAME_IMM_W != 8)
    begin : g_check_frame_imm_w
        $error("blsu_unit frame offset is taken from imm bits 7 to 2");
    end

    if (BLSU_FRAME_POINTER_INDEX == BLSU_STACK_POINTER_INDEX)
    begin : g_check_pointer_index
        $error("blsu_unit frame and stack pointers need distinct slots");
    end

    // ****************************************************************
    // decode
    // ****************************************************************
    assign is_long  = (issue_mode == BLSU_AM_LARGE_ADD) ||
                      (issue_mode == BLSU_AM_LARGE_SUB);
    assign is_index = (issue_mode == BLSU_AM_I_PLAIN) ||
                      (issue_mode == BLSU_AM_I_POSTINC) ||
                      (issue_mode == BLSU_AM_I_POSTDEC) ||
                      (issue_mode == BLSU_AM_I_MOD);
    // a long encoding paired with another instruction is not executed
    assign issue_refused = issue_valid && is_long && issue_parallel;
    assign accept        = issue_valid && !issue_refused;
    assign long_insn     = issue_valid && is_long;

    always_comb
    begin
        if (is_index)
            base = ireg[idx_sel];
        else if (issue_mode == BLSU_AM_FRAME)
            base = preg[BLSU_FRAME_POINTER_INDEX];
        else
            base = preg[ptr_sel];
        step_reg = (issue_mode == BLSU_AM_I_MOD) ? mreg[mod_sel] : preg[ptr2_sel];
    end

    blsu_agen u_agen
    (
        .op         (issue_op),
        .mode       (issue_mode),
        .base       (base),
        .step_reg   (step_reg),
        .imm        (imm),
        .same_ptr   (ptr_sel == ptr2_sel),
        .addr       (ea),
        .new_base   (new_base),
        .base_we    (base_we),
        .misaligned (misaligned)
    );

    // ****************************************************************
    // circular wrap on modified index registers
    // ****************************************************************
    // zero length means linear; uninitialised length gives odd wraps
    always_comb
    begin
        next_index = new_base;
        if (lreg[idx_sel] != 32'h0)
        begin
            if (new_base >= breg[idx_sel] + lreg[idx_sel])
                next_index = new_base - lreg[idx_sel];
            else if (new_base < breg[idx_sel])
                next_index = new_base + lreg[idx_sel];
        end
    end

    // ****************************************************************
    // memory request
    // ****************************************************************
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
            mem_addr  <= 32'h0;
            mem_wdata <= 32'h0;
        end
        else
        begin
            // the misaligned write never reaches memory
            mem_req <= accept && !misaligned;
            mem_we  <= accept && !misaligned && (issue_op != BLSU_OP_LDSB);
            if (accept)
            begin
                mem_addr <= ea;
                if (issue_op == BLSU_OP_STP)
                    mem_wdata <= preg[src_sel];
                else
                    mem_wdata <= dreg[src_sel];
            end
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            misalign_exc <= 1'b0;
            done         <= 1'b0;
        end
        else
        begin
            misalign_exc <= accept && misaligned;
            done         <= accept;
        end
    end

    // ****************************************************************
    // load return
    // ****************************************************************
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            load_pending <= 1'b0;
            load_dst     <= 3'h0;
        end
        else
        begin
            load_pending <= accept && (issue_op == BLSU_OP_LDSB);
            if (accept)
                load_dst <= dst_sel;
        end
    end

    // ****************************************************************
    // register files
    // ****************************************************************
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int k = 0; k < 8; k++)
                dreg[k] <= 32'h0;
        end
        else
        begin
            if (dreg_wr)
                dreg[dreg_wr_sel] <= dreg_wr_data;
            if (load_pending)
                dreg[load_dst] <= {{24{mem_rdata[7]}}, mem_rdata[7:0]};
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int k = 0; k < 8; k++)
                preg[k] <= 32'h0;
        end
        else
        begin
            if (preg_wr)
                preg[preg_wr_sel] <= preg_wr_data;
            // pointer update only when the access went ahead
            if (accept && !misaligned && base_we && !is_index)
                preg[ptr_sel] <= new_base;
        end
    end

    // index, length and base have no reset: boot code clears them
    always_ff @(posedge clock)
    begin
        if (dag_wr)
        begin
            ireg[dag_wr_sel] <= dag_wr_index;
            lreg[dag_wr_sel] <= dag_wr_length;
            breg[dag_wr_sel] <= dag_wr_base;
            mreg[dag_wr_sel] <= dag_wr_modify;
        end
        else if (accept && !misaligned && base_we && is_index)
            ireg[idx_sel] <= next_index;
    end

    generate
        for (genvar g = 0; g < 8; g++)
        begin : g_view
            assign dreg_view[g] = dreg[g];
            assign preg_view[g] = preg[g];
        end
    endgenerate

endmodule // blsu_unit

// [dv/blsu_mem_model.sv]
// data memory stand-in: byte reads return a pattern of the address
// assumes a single-cycle memory, read data looked at while mem_req is high
`timescale 1ns/1ps

module blsu_mem_model
(
    // clock
    input  wire logic        clock,
    // memory port
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_addr,
    output logic [31:0]      mem_rdata
);
    // an idle bus shows a pattern that flips every cycle, never a held value
    logic [31:0] junk = 32'h0f0f_0f0f;
    always @(posedge clock) junk <= ~junk;

    assign mem_rdata = (mem_req && !mem_we) ? {junk[31:8], mem_addr[7:0] ^ 8'h5a} : junk;
endmodule // blsu_mem_model

// [dv/blsu_unit_monitor.sv]
// checker for the byte load / word store unit
// assumes it is bound onto blsu_unit and sees only its ports
`timescale 1ns/1ps

module blsu_unit_monitor
    import blsu_pkg::*;
(
    // clock and reset
    input wire logic               clock,
    input wire logic               rstn,
    // issue side
    input wire logic               issue_valid,
    input wire blsu_pkg::blsu_op_e issue_op,
    input wire blsu_pkg::blsu_am_e issue_mode,
    input wire logic               issue_parallel,
    // memory and status
    input wire logic               mem_req,
    input wire logic               mem_we,
    input wire logic [31:0]        mem_addr,
    input wire logic               long_insn,
    input wire logic               issue_refused,
    input wire logic               misalign_exc,
    input wire logic               done
);
    logic is_long;

    assign is_long = issue_mode inside {BLSU_AM_LARGE_ADD, BLSU_AM_LARGE_SUB};

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    sequence s_take;
        issue_valid && !issue_refused;
    endsequence
    sequence s_write;
        mem_req && mem_we;
    endsequence

    chk_long_decode: assert property (issue_valid |-> long_insn == is_long)
        else $error("long flag disagrees with mode");
    chk_long_alone: assert property (issue_valid && is_long && issue_parallel |-> issue_refused)
        else $error("paired long form not refused");
    chk_short_paired: assert property (issue_valid && !is_long |-> !issue_refused)
        else $error("short form refused");
    chk_refused_quiet: assert property (issue_refused |=> !mem_req && !done && !misalign_exc)
        else $error("refused issue had an effect");
    chk_load_noalign: assert property (s_take ##0 issue_op == BLSU_OP_LDSB |=>
        mem_req && !mem_we && !misalign_exc && done)
        else $error("byte load not a plain read");
    chk_store_align: assert property (s_write |-> mem_addr[1:0] == 2'h0)
        else $error("word write on unaligned address");
    chk_exc_no_write: assert property (misalign_exc |-> !mem_req)
        else $error("memory request with misalign exception");
    chk_store_outcome: assert property (s_take ##0 issue_op != BLSU_OP_LDSB |=>
        (mem_req && mem_we) != misalign_exc)
        else $error("store neither written nor trapped");
endmodule // blsu_unit_monitor

// [dv/tb_top.sv]
// self-checking bench for the byte load / word store unit
// assumes blsu_mem_model on the memory port and blsu_unit_monitor bound in
`timescale 1ns/1ps

module tb_top;
    import blsu_pkg::*;
    logic clock, rstn = 0, issue_valid = 0, issue_parallel = 0, lng, rf;
    logic dreg_wr = 0, preg_wr = 0, dag_wr = 0, mem_req, mem_we;
    logic long_insn, issue_refused, misalign_exc, done;
    blsu_op_e issue_op = BLSU_OP_LDSB;
    blsu_am_e issue_mode = BLSU_AM_PLAIN;
    logic [2:0] ptr_sel = 0, ptr2_sel = 0, src_sel = 0, dst_sel = 0;
    logic [2:0] dreg_wr_sel = 0, preg_wr_sel = 0;
    logic [1:0] idx_sel = 0, mod_sel = 0, dag_wr_sel = 0;
    logic [16:0] imm = 0;
    logic [31:0] dreg_wr_data = 0, preg_wr_data = 0, dag_wr_index = 0, dag_wr_length = 0;
    logic [31:0] dag_wr_base = 0, dag_wr_modify = 0, mem_addr, mem_wdata, mem_rdata;
    logic [31:0] dv [8];
    logic [31:0] pv [8];
    int fail_count = 0, total_checks = 0, cyc = 0;
    localparam logic [31:0] DW = 32'h8765_4321;

    initial
    begin
        clock = 0;
        forever #4 clock = ~clock;
    end

    blsu_unit dut (.clock, .rstn, .issue_valid, .issue_op, .issue_mode, .ptr_sel, .ptr2_sel,
        .idx_sel, .mod_sel, .src_sel, .dst_sel, .imm, .issue_parallel, .dreg_wr, .dreg_wr_sel,
        .dreg_wr_data, .preg_wr, .preg_wr_sel, .preg_wr_data, .dag_wr, .dag_wr_sel,
        .dag_wr_index, .dag_wr_length, .dag_wr_base, .dag_wr_modify, .mem_req, .mem_we,
        .mem_addr, .mem_wdata, .mem_rdata, .long_insn, .issue_refused, .misalign_exc, .done,
        .dreg_view(dv), .preg_view(pv));
    blsu_mem_model mem (.clock, .mem_req, .mem_we, .mem_addr, .mem_rdata);

    // ****************************************************************
    // drivers and comparison
    // ****************************************************************
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    task ldp(input logic [2:0] s, input logic [31:0] v, input logic d);
        @(posedge clock);
        {preg_wr, dreg_wr, preg_wr_sel, dreg_wr_sel} <= {!d, d, s, s};
        {preg_wr_data, dreg_wr_data} <= {v, v};
        @(posedge clock);
        {preg_wr, dreg_wr} <= 2'h0;
    endtask
    task ldi(input logic [1:0] s, input logic [31:0] i, l, b, m);
        @(posedge clock);
        {dag_wr, dag_wr_sel, dag_wr_index, dag_wr_length, dag_wr_base} <= {1'b1, s, i, l, b};
        dag_wr_modify <= m;
        @(posedge clock);
        dag_wr <= 1'b0;
    endtask
    // one instruction; outputs are looked at just after the edge that answers it
    task go(input blsu_op_e o, input blsu_am_e m, input logic [2:0] p, a, s,
            input logic [16:0] i, input logic par);
        @(posedge clock);
        {issue_valid, ptr_sel, ptr2_sel, idx_sel, mod_sel} <= {1'b1, p, a, a[1:0], a[1:0]};
        issue_op <= o;
        issue_mode <= m;
        {src_sel, dst_sel, imm, issue_parallel} <= {s, s, i, par};
        #1 lng = long_insn;
        rf = issue_refused;
        chk("long flag", {31'h0, m == BLSU_AM_LARGE_ADD || m == BLSU_AM_LARGE_SUB}, {31'h0, lng});
        @(posedge clock);
        {issue_valid, issue_parallel} <= 2'h0;
        #1;
    endtask
    task ld(input blsu_am_e m, input logic [16:0] i, input logic [31:0] ea, ep);
        logic [7:0] b;
        go(BLSU_OP_LDSB, m, 3'h1, 3'h0, 3'h2, i, 1'b0);
        chk("load req", 32'h5, {29'h0, done, misalign_exc, mem_req && !mem_we});
        chk("load addr", ea, mem_addr);
        chk("load ptr", ep, pv[1]);
        @(posedge clock);
        #1 b = ea[7:0] ^ 8'h5a;
        chk("load data", {{24{b[7]}}, b}, dv[2]);
    endtask
    task st(input blsu_op_e o, input blsu_am_e m, input logic [2:0] p, a, s,
            input logic [16:0] i, input logic [31:0] ea, ep, ed);
        go(o, m, p, a, s, i, 1'b0);
        chk("store kind", 32'h7, {29'h0, done, mem_we, mem_req});
        chk("store addr", ea, mem_addr);
        chk("store data", ed, mem_wdata);
        chk("store ptr", ep, pv[p]);
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task t_load;
        ldp(3'h1, 32'h1000, 1'b0);
        ld(BLSU_AM_POSTINC, 17'h0, 32'h1000, 32'h1001);
        ld(BLSU_AM_POSTDEC, 17'h0, 32'h1001, 32'h1000);
        ld(BLSU_AM_LARGE_ADD, 17'h7fff, 32'h8fff, 32'h1000);
        ld(BLSU_AM_LARGE_SUB, 17'h0e01, 32'h01ff, 32'h1000);
    endtask
    task t_store;
        ldp(3'h3, 32'h2000, 1'b0);
        ldp(3'h6, 32'h3000, 1'b0);
        ldp(3'h7, 32'h40000, 1'b0);
        ldp(3'h5, 32'h10, 1'b0);
        ldp(3'h4, DW, 1'b1);
        st(BLSU_OP_STP, BLSU_AM_POSTINC, 3, 0, 6, 0, 32'h2000, 32'h2004, 32'h3000);
        st(BLSU_OP_STD, BLSU_AM_POSTDEC, 3, 0, 4, 0, 32'h2004, 32'h2000, DW);
        st(BLSU_OP_STD, BLSU_AM_SMALL_OFF, 3, 0, 4, 17'h3c, 32'h203c, 32'h2000, DW);
        st(BLSU_OP_STP, BLSU_AM_LARGE_SUB, 7, 0, 3, 17'h1fffc, 32'h20004, 32'h40000, 32'h2000);
        st(BLSU_OP_STD, BLSU_AM_LARGE_ADD, 3, 0, 4, 17'h1fffc, 32'h21ffc, 32'h2000, DW);
        st(BLSU_OP_STD, BLSU_AM_FRAME, 7, 0, 4, 17'h80, 32'h3ff80, 32'h40000, DW);
    endtask
    task t_misalign;
        ldp(3'h2, 32'h2002, 1'b0);
        go(BLSU_OP_STD, BLSU_AM_POSTINC, 3'h2, 3'h0, 3'h4, 17'h0, 1'b0);
        chk("misalign", 32'h5, {29'h0, done, mem_req, misalign_exc});
        chk("misalign ptr", 32'h2002, pv[2]);
    endtask
    task t_ptr_idx;
        st(BLSU_OP_STD, BLSU_AM_PTR_IDX, 3, 5, 4, 0, 32'h2000, 32'h2010, DW);
        st(BLSU_OP_STD, BLSU_AM_PTR_IDX, 3, 3, 4, 0, 32'h2010, 32'h2010, DW);
    endtask
    task t_index;
        ldi(2'h1, 32'h20c, 32'h10, 32'h200, 32'h8);
        st(BLSU_OP_STD, BLSU_AM_I_POSTINC, 0, 1, 4, 0, 32'h20c, 0, DW);
        st(BLSU_OP_STD, BLSU_AM_I_PLAIN, 0, 1, 4, 0, 32'h200, 0, DW);
        st(BLSU_OP_STD, BLSU_AM_I_MOD, 0, 1, 4, 0, 32'h200, 0, DW);
        st(BLSU_OP_STD, BLSU_AM_I_POSTDEC, 0, 1, 4, 0, 32'h208, 0, DW);
        st(BLSU_OP_STD, BLSU_AM_I_PLAIN, 0, 1, 4, 0, 32'h204, 0, DW);
        st(BLSU_OP_STD, BLSU_AM_I_POSTDEC, 0, 1, 4, 0, 32'h204, 0, DW);
        st(BLSU_OP_STD, BLSU_AM_I_POSTDEC, 0, 1, 4, 0, 32'h200, 0, DW);
        st(BLSU_OP_STD, BLSU_AM_I_PLAIN, 0, 1, 4, 0, 32'h20c, 0, DW);
    endtask
    task t_refuse;
        go(BLSU_OP_STD, BLSU_AM_LARGE_ADD, 3'h3, 3'h0, 3'h4, 17'h4, 1'b1);
        chk("refused", 32'h2, {30'h0, rf, mem_req || misalign_exc});
        go(BLSU_OP_STD, BLSU_AM_PLAIN, 3'h3, 3'h0, 3'h4, 17'h0, 1'b1);
        chk("paired short", 32'h1, {30'h0, rf, mem_req});
    endtask

    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            fail_count++;
            end_sim;
        end
    end

    initial
    begin
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        // boot clears every circular buffer set so addressing starts linear
        for (int k = 0; k < 4; k++) ldi(k[1:0], 0, 0, 0, 0);
        t_load;
        t_store;
        t_misalign;
        t_ptr_idx;
        t_index;
        t_refuse;
        end_sim;
    end
endmodule // tb_top

bind blsu_unit blsu_unit_monitor mon (.clock, .rstn, .issue_valid, .issue_op, .issue_mode,
    .issue_parallel, .mem_req, .mem_we, .mem_addr, .long_insn, .issue_refused, .misalign_exc,
    .done);
